// [hdl/adcirq_pkg.sv]
// package: register map, field positions and reset values of the flag block
package adcirq_pkg;
  localparam int unsigned NUM_CH = 12;
  // register byte addresses
  localparam logic [11:0] FLAGS_OFFSET     = 12'h068;
  localparam logic [11:0] IRQ_EN_OFFSET    = 12'h0a0;
  localparam logic [11:0] SEQ_MODE_OFFSET  = 12'h0a4;
  localparam logic [11:0] THR_EN_OFFSET    = 12'h0a8;
  localparam logic [11:0] IRQ_OUT_OFFSET   = 12'h0ac;
  // flag register fields
  localparam int unsigned THR_FLAG_LSB     = 0;
  localparam int unsigned OVR_LSB          = 12;
  localparam int unsigned SEQ_A_OVR_BIT    = 24;
  localparam int unsigned SEQ_B_OVR_BIT    = 25;
  localparam int unsigned SEQ_A_FLAG_BIT   = 28;
  localparam int unsigned SEQ_B_FLAG_BIT   = 29;
  localparam int unsigned THR_SUM_BIT      = 30;
  localparam int unsigned OVR_SUM_BIT      = 31;
  // irq enable register fields
  localparam int unsigned EN_SEQA_BIT      = 0;
  localparam int unsigned EN_SEQB_BIT      = 1;
  localparam int unsigned EN_OVR_BIT       = 2;
  // mode register fields: 0 per conversion, 1 end of sequence
  localparam int unsigned MODE_A_BIT       = 0;
  localparam int unsigned MODE_B_BIT       = 1;
  // reset values
  localparam logic [31:0] FLAGS_RESET      = 32'h0000_0000;
  localparam logic [2:0]  IRQ_EN_RESET     = 3'h0;
  localparam logic [1:0]  SEQ_MODE_RESET   = 2'h0;
  localparam logic [23:0] THR_EN_RESET     = 24'h00_0000;
endpackage : adcirq_pkg

// [hdl/adcirq_seq_flag.sv]
// one sequence event flag with its two reporting modes
`timescale 1ns/1ps
module adcirq_seq_flag (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // mode and events
  input  wire logic eos_mode,
  input  wire logic result_valid_bit,
  input  wire logic seq_done,
  input  wire logic w1c,
  // flag
  output logic      flag
);
  logic sticky;

  // end-of-sequence latch: a completion in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky <= 1'b0;
    end else if (seq_done) begin
      sticky <= 1'b1;
    end else if (w1c) begin
      sticky <= 1'b0;
    end
  end

  // per-conversion mode mirrors the valid bit, cleared by the result read
  assign flag = eos_mode ? sticky : result_valid_bit;

  seq_set_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_done |=> sticky)
    else $error("completion lost against clear");
  seq_w1c_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    w1c && !seq_done && sticky |=> !sticky)
    else $error("write one did not clear sequence flag");
endmodule : adcirq_seq_flag

// [hdl/adcirq_flags.sv]
// converter event flag register, summary flags, irq and dma request outputs
`timescale 1ns/1ps
module adcirq_flags #(
  parameter int unsigned NCH = adcirq_pkg::NUM_CH
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter status, same clock domain
  input  wire logic [NCH-1:0] ch_out_of_range,
  input  wire logic [NCH-1:0] ch_crossing,
  input  wire logic [NCH-1:0] ch_overrun,
  input  wire logic        seq_a_valid,
  input  wire logic        seq_b_valid,
  input  wire logic        seq_a_overrun,
  input  wire logic        seq_b_overrun,
  input  wire logic        seq_a_done,
  input  wire logic        seq_b_done,
  // requests
  output logic             seq_a_event_flag,
  output logic             seq_b_event_flag,
  output logic             threshold_summary_flag,
  output logic             overrun_summary_flag,
  output logic             seq_a_dma_req,
  output logic             seq_b_dma_req,
  output logic             seq_a_irq,
  output logic             seq_b_irq,
  output logic             threshold_irq,
  output logic             overrun_irq
);
  logic [NCH-1:0]   channel_threshold_flag;
  logic [2:0]       irq_enable_reg;
  logic [1:0]       seq_mode;
  logic [2*NCH-1:0] thr_enable;
  logic [31:0]      flags_word;
  logic [31:0]      next_prdata;
  logic             wr_en;
  logic             rd_en;
  logic             w1c_flags;
  logic             mapped;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction : hit

  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign w1c_flags = wr_en && hit(paddr, adcirq_pkg::FLAGS_OFFSET);
  assign mapped    = hit(paddr, adcirq_pkg::FLAGS_OFFSET)
                  || hit(paddr, adcirq_pkg::IRQ_EN_OFFSET)
                  || hit(paddr, adcirq_pkg::SEQ_MODE_OFFSET)
                  || hit(paddr, adcirq_pkg::THR_EN_OFFSET)
                  || hit(paddr, adcirq_pkg::IRQ_OUT_OFFSET);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= adcirq_pkg::IRQ_EN_RESET;
      seq_mode       <= adcirq_pkg::SEQ_MODE_RESET;
      thr_enable     <= adcirq_pkg::THR_EN_RESET[2*NCH-1:0];
    end else if (wr_en) begin
      if (hit(paddr, adcirq_pkg::IRQ_EN_OFFSET)) begin
        irq_enable_reg <= pwdata[2:0];
      end else if (hit(paddr, adcirq_pkg::SEQ_MODE_OFFSET)) begin
        seq_mode <= pwdata[1:0];
      end else if (hit(paddr, adcirq_pkg::THR_EN_OFFSET)) begin
        thr_enable <= pwdata[2*NCH-1:0];
      end
    end
  end

  // channel threshold flags: enabled event sets, write one clears
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_thr
      logic ev;
      assign ev = (ch_out_of_range[g] && thr_enable[2*g])
               || (ch_crossing[g] && thr_enable[2*g+1]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          channel_threshold_flag[g] <= 1'b0;
        end else if (ev) begin
          channel_threshold_flag[g] <= 1'b1;
        end else if (w1c_flags && pwdata[adcirq_pkg::THR_FLAG_LSB+g]) begin
          channel_threshold_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate

  adcirq_seq_flag u_seq_a (
    .pclk             (pclk),
    .presetn          (presetn),
    .eos_mode         (seq_mode[adcirq_pkg::MODE_A_BIT]),
    .result_valid_bit (seq_a_valid),
    .seq_done         (seq_a_done),
    .w1c              (w1c_flags && pwdata[adcirq_pkg::SEQ_A_FLAG_BIT]),
    .flag             (seq_a_event_flag)
  );
  adcirq_seq_flag u_seq_b (
    .pclk             (pclk),
    .presetn          (presetn),
    .eos_mode         (seq_mode[adcirq_pkg::MODE_B_BIT]),
    .result_valid_bit (seq_b_valid),
    .seq_done         (seq_b_done),
    .w1c              (w1c_flags && pwdata[adcirq_pkg::SEQ_B_FLAG_BIT]),
    .flag             (seq_b_event_flag)
  );

  // summaries are pure functions of their sources (plus the mode bits for overrun), so writes reach them only through those sources and the mode register
  assign threshold_summary_flag = |channel_threshold_flag;
  assign overrun_summary_flag = (|ch_overrun)
    || (seq_a_overrun && !seq_mode[adcirq_pkg::MODE_A_BIT])
    || (seq_b_overrun && !seq_mode[adcirq_pkg::MODE_B_BIT]);

  assign seq_a_dma_req = seq_a_event_flag;
  assign seq_b_dma_req = seq_b_event_flag;
  assign seq_a_irq = seq_a_event_flag
                  && irq_enable_reg[adcirq_pkg::EN_SEQA_BIT];
  assign seq_b_irq = seq_b_event_flag
                  && irq_enable_reg[adcirq_pkg::EN_SEQB_BIT];
  // per-kind enables already gate the threshold path
  assign threshold_irq = threshold_summary_flag;
  assign overrun_irq   = overrun_summary_flag
                      && irq_enable_reg[adcirq_pkg::EN_OVR_BIT];

  always_comb begin
    flags_word = adcirq_pkg::FLAGS_RESET;
    flags_word[adcirq_pkg::THR_FLAG_LSB +: NCH] = channel_threshold_flag;
    flags_word[adcirq_pkg::OVR_LSB +: NCH]   = ch_overrun;
    flags_word[adcirq_pkg::SEQ_A_OVR_BIT]    = seq_a_overrun;
    flags_word[adcirq_pkg::SEQ_B_OVR_BIT]    = seq_b_overrun;
    flags_word[adcirq_pkg::SEQ_A_FLAG_BIT]   = seq_a_event_flag;
    flags_word[adcirq_pkg::SEQ_B_FLAG_BIT]   = seq_b_event_flag;
    flags_word[adcirq_pkg::THR_SUM_BIT]      = threshold_summary_flag;
    flags_word[adcirq_pkg::OVR_SUM_BIT]      = overrun_summary_flag;
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr, adcirq_pkg::FLAGS_OFFSET)) begin
      next_prdata = flags_word;
    end else if (hit(paddr, adcirq_pkg::IRQ_EN_OFFSET)) begin
      next_prdata[2:0] = irq_enable_reg;
    end else if (hit(paddr, adcirq_pkg::SEQ_MODE_OFFSET)) begin
      next_prdata[1:0] = seq_mode;
    end else if (hit(paddr, adcirq_pkg::THR_EN_OFFSET)) begin
      next_prdata[2*NCH-1:0] = thr_enable;
    end else if (hit(paddr, adcirq_pkg::IRQ_OUT_OFFSET)) begin
      next_prdata[3:0] = {overrun_irq, threshold_irq, seq_b_irq, seq_a_irq};
    end
  end

  // read data captured in the setup cycle so the access phase sees a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // channel threshold flags, checked on channel 0, and the threshold summary over all channels
  thr_sum_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    threshold_summary_flag == (channel_threshold_flag != '0))
    else $error("threshold summary mismatch");
  thr_w1c_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (w1c_flags && pwdata[adcirq_pkg::THR_FLAG_LSB] && !g_thr[0].ev)
    |=> !channel_threshold_flag[0])
    else $error("channel 0 threshold not cleared");
  thr_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    channel_threshold_flag[0]
    && !(w1c_flags && pwdata[adcirq_pkg::THR_FLAG_LSB])
    |=> channel_threshold_flag[0])
    else $error("threshold flag dropped without write one");
  thr_enable_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !channel_threshold_flag[0] && ch_out_of_range[0] && thr_enable[0]
    |=> channel_threshold_flag[0])
    else $error("enabled out of range event missed");
  thr_cross_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !channel_threshold_flag[0] && ch_crossing[0] && thr_enable[1]
    |=> channel_threshold_flag[0])
    else $error("enabled crossing event missed");
  thr_masked_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !channel_threshold_flag[0]
    && !(ch_out_of_range[0] && thr_enable[0])
    && !(ch_crossing[0] && thr_enable[1])
    |=> !channel_threshold_flag[0])
    else $error("threshold flag set without enabled event");
  thr_set_wins_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    g_thr[0].ev |=> channel_threshold_flag[0])
    else $error("threshold event lost against clear");
  thr_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(threshold_summary_flag) |-> $past(w1c_flags))
    else $error("threshold summary dropped without write one");
  sum_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    w1c_flags && (pwdata[adcirq_pkg::THR_FLAG_LSB +: NCH] == '0)
    && threshold_summary_flag |=> threshold_summary_flag)
    else $error("summary write cleared threshold summary");

  // overrun summary
  ovr_seq_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_a_overrun && !seq_mode[0] |-> overrun_summary_flag)
    else $error("sequence overrun not summarised");
  ovr_seq_b_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_b_overrun && !seq_mode[1] |-> overrun_summary_flag)
    else $error("sequence b overrun not summarised");
  ovr_chan_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ch_overrun != '0 |-> overrun_summary_flag)
    else $error("channel overrun not summarised");
  ovr_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ch_overrun == '0
    && !(seq_a_overrun && !seq_mode[adcirq_pkg::MODE_A_BIT])
    && !(seq_b_overrun && !seq_mode[adcirq_pkg::MODE_B_BIT])
    |-> !overrun_summary_flag)
    else $error("overrun summary stuck without source");
  ovr_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    overrun_irq == (overrun_summary_flag
                    && irq_enable_reg[adcirq_pkg::EN_OVR_BIT]))
    else $error("overrun irq not gated by enable");

  // request outputs
  irq_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_a_irq |-> irq_enable_reg[0] && seq_a_dma_req)
    else $error("sequence irq without enable");
  irq_b_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_b_irq == (seq_b_event_flag && irq_enable_reg[1]))
    else $error("sequence b irq not gated by enable");
  dma_pair_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_a_dma_req == seq_a_event_flag
    && seq_b_dma_req == seq_b_event_flag)
    else $error("dma request differs from sequence flag");

  // sequence flags in both reporting modes
  mirror_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !seq_mode[0] |-> seq_a_event_flag == seq_a_valid)
    else $error("per conversion flag not mirroring");
  mirror_b_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !seq_mode[1] |-> seq_b_event_flag == seq_b_valid)
    else $error("per conversion b flag not mirroring");
  seq_a_eos_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_a_done |=> !seq_mode[0] || seq_a_event_flag)
    else $error("sequence a completion not flagged");
  seq_b_eos_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_b_done |=> !seq_mode[1] || seq_b_event_flag)
    else $error("sequence b completion not flagged");
  seq_a_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_mode[0] && seq_a_event_flag
    && !(w1c_flags && pwdata[adcirq_pkg::SEQ_A_FLAG_BIT])
    |=> !seq_mode[0] || seq_a_event_flag)
    else $error("sequence a flag dropped without write one");
  seq_b_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_mode[1] && seq_b_event_flag
    && !(w1c_flags && pwdata[adcirq_pkg::SEQ_B_FLAG_BIT])
    |=> !seq_mode[1] || seq_b_event_flag)
    else $error("sequence b flag dropped without write one");
  seq_a_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_mode[0] && w1c_flags && !seq_a_done
    && pwdata[adcirq_pkg::SEQ_A_FLAG_BIT]
    |=> !seq_mode[0] || !seq_a_event_flag)
    else $error("sequence a flag not cleared by write one");
  seq_b_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    seq_mode[1] && w1c_flags && !seq_b_done
    && pwdata[adcirq_pkg::SEQ_B_FLAG_BIT]
    |=> !seq_mode[1] || !seq_b_event_flag)
    else $error("sequence b flag not cleared by write one");

  // register bus
  rd_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_en |=> $stable(prdata))
    else $error("read data changed at end of access");
  rd_flags_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit(paddr, adcirq_pkg::FLAGS_OFFSET)
    |=> prdata[adcirq_pkg::OVR_LSB +: NCH] == $past(ch_overrun))
    else $error("read of overrun mirror bits wrong");
  ctrl_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_en |=> $stable(irq_enable_reg) && $stable(seq_mode)
    && $stable(thr_enable))
    else $error("control register changed without write");
endmodule : adcirq_flags

// [tb/adc_irq_flag_aggregator_test.sv]
// self-checking bench for the converter event flag block
`timescale 1ns/1ps
module adc_irq_flag_aggregator_test;
  localparam logic [11:0] FLG  = adcirq_pkg::FLAGS_OFFSET;
  localparam logic [11:0] IEN  = adcirq_pkg::IRQ_EN_OFFSET;
  localparam logic [11:0] MODE = adcirq_pkg::SEQ_MODE_OFFSET;
  localparam logic [11:0] TEN  = adcirq_pkg::THR_EN_OFFSET;
  localparam logic [11:0] IOUT = adcirq_pkg::IRQ_OUT_OFFSET;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr, oor, crs, ch_ovr, t, o, c;
  logic [31:0] pwdata, prdata, q, m;
  logic [1:0]  sv, sd, so, coinc, md;
  wire  [1:0]  fl, dma, irq;
  logic        thr_f, ovr_f, thr_irq, ovr_irq, sum;
  logic [23:0] ten;
  logic [2:0]  en;
  int          failures, compares, cycles;

  adcirq_flags adcirq_flags_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch_out_of_range(oor),
    .ch_crossing(crs), .ch_overrun(ch_ovr), .seq_a_valid(sv[0]),
    .seq_b_valid(sv[1]), .seq_a_overrun(so[0]), .seq_b_overrun(so[1]),
    .seq_a_done(sd[0]), .seq_b_done(sd[1]), .seq_a_event_flag(fl[0]),
    .seq_b_event_flag(fl[1]), .threshold_summary_flag(thr_f),
    .overrun_summary_flag(ovr_f), .seq_a_dma_req(dma[0]),
    .seq_b_dma_req(dma[1]), .seq_a_irq(irq[0]), .seq_b_irq(irq[1]),
    .threshold_irq(thr_irq), .overrun_irq(ovr_irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // request held from setup until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    logic rdy;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    sd      <= coinc;
    // values settled before the edge are those the edge samples
    do begin
      @(negedge pclk);
      rdy = pready;
      q   = prdata;
      e   = pslverr;
      @(posedge pclk);
    end while (rdy !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    sd      <= 2'h0;
  endtask : apb

  task automatic pulse(input logic [11:0] po, pc, input logic [1:0] ps);
    @(posedge pclk);
    oor <= po;
    crs <= pc;
    sd  <= ps;
    @(posedge pclk);
    oor <= 12'h000;
    crs <= 12'h000;
    sd  <= 2'h0;
    @(negedge pclk);
  endtask : pulse

  function automatic logic [11:0] thr_exp(input logic [23:0] te,
                                          input logic [11:0] eo, ec);
    logic [11:0] r;
    for (int g = 0; g < 12; g++) begin
      r[g] = (eo[g] & te[2*g]) | (ec[g] & te[2*g+1]);
    end
    return r;
  endfunction : thr_exp

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {oor, crs, ch_ovr, sv, sd, so, coinc} = '0;
    presetn = 1'b0;
    void'($urandom(32'hde16));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FLG, 32'h0);
    chk("flags reset", 32'h0, q);
    apb(1'b0, TEN, 32'h0);
    chk("thr en reset", 32'h0, q);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped err", 32'h1, 32'(e));
    apb(1'b1, 12'h0f0, '1);
    chk("unmapped wr err", 32'h1, 32'(e));
    for (int k = 0; k < 6; k++) begin
      en = 3'($urandom);
      apb(1'b1, IEN, 32'(en));
      apb(1'b1, MODE, 32'h0);
      sv <= 2'($urandom);
      @(negedge pclk);
      chk("seq flags", 32'(sv), 32'(fl));
      chk("dma req", 32'(sv), 32'(dma));
      chk("seq irq", 32'(sv & en[1:0]), 32'(irq));
      apb(1'b0, FLG, 32'h0);
      chk("flags 29:28", 32'(sv), 32'(q[29:28]));
      sv <= 2'h0;
      @(negedge pclk);
      chk("seq after read", 32'h0, 32'(fl));
      apb(1'b1, MODE, 32'h3);
      md = (k == 0) ? 2'h3 : 2'($urandom);
      sv <= 2'($urandom);
      pulse(12'h000, 12'h000, md);
      apb(1'b1, FLG, 32'h0);
      @(negedge pclk);
      chk("eos flags", 32'(md), 32'(fl));
      chk("eos irq", 32'(md & en[1:0]), 32'(irq));
      // completion lands in the same cycle as the clearing write
      coinc = 2'($urandom);
      apb(1'b1, FLG, 32'h3000_0000);
      @(negedge pclk);
      chk("eos clear", 32'(coinc), 32'(fl));
      coinc = 2'h0;
      apb(1'b1, FLG, 32'h3000_0000);
      sv <= 2'h0;
    end
    for (int k = 0; k < 4; k++) begin
      ten = (k == 0) ? 24'hff_ffff : 24'($urandom);
      apb(1'b1, TEN, 32'(ten));
      o = 12'($urandom);
      c = 12'($urandom);
      t = thr_exp(ten, o, c);
      pulse(o, c, 2'h0);
      chk("thr summary", 32'(|t), 32'(thr_f));
      chk("thr irq", 32'(|t), 32'(thr_irq));
      apb(1'b1, FLG, 32'hc000_0000);
      apb(1'b0, FLG, 32'h0);
      chk("thr flags", 32'(t), 32'(q[11:0]));
      m = 32'(t & 12'($urandom));
      apb(1'b1, FLG, m);
      @(negedge pclk);
      chk("thr partial", 32'(|(t & ~m[11:0])), 32'(thr_f));
      apb(1'b1, FLG, 32'h0000_0fff);
      @(negedge pclk);
      chk("thr cleared", 32'h0, 32'(thr_f));
    end
    // reset in mid-run with flags and control registers set
    apb(1'b1, TEN, 32'h00ff_ffff);
    apb(1'b1, MODE, 32'h3);
    pulse(12'hfff, 12'h000, 2'h3);
    chk("set before reset", 32'h3, 32'(fl));
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("thr after reset", 32'h0, 32'(thr_f));
    chk("seq after reset", 32'h0, 32'(fl));
    apb(1'b0, TEN, 32'h0);
    chk("thr en after reset", 32'h0, q);
    for (int k = 0; k < 4; k++) begin
      en = 3'($urandom);
      md = 2'($urandom);
      apb(1'b1, IEN, 32'(en));
      apb(1'b1, MODE, 32'(md));
      ch_ovr <= (k == 0) ? 12'h000 : 12'($urandom);
      so <= (k == 0) ? 2'h3 : 2'($urandom);
      @(negedge pclk);
      sum = (|ch_ovr) | (|(so & ~md));
      chk("ovr summary", 32'(sum), 32'(ovr_f));
      chk("ovr irq", 32'(sum & en[2]), 32'(ovr_irq));
      apb(1'b0, FLG, 32'h0);
      chk("ovr mirrors", 32'({so, ch_ovr}), 32'(q[25:12]));
      apb(1'b0, IOUT, 32'h0);
      chk("irq out", 32'({sum & en[2], 3'h0}), q);
      apb(1'b0, IEN, 32'h0);
      chk("irq en back", 32'(en), q);
      apb(1'b0, MODE, 32'h0);
      chk("mode back", 32'(md), q);
      ch_ovr <= 12'h000;
      so <= 2'h0;
      @(negedge pclk);
      chk("ovr cleared", 32'h0, 32'(ovr_f));
    end
    stop_test();
  end
endmodule : adc_irq_flag_aggregator_test
